// ---- hdl/mcd_mode_ctrl.sv ----
/*
  operating mode control: reset-time mode capture, mode and mapping registers,
  e clock, visibility, wait shutdown, port emulation and debug state.
  assumes an 8-bit register port addressed by offset, synchronous pin inputs.
*/
//
// How it works
// - mode pins are latched into special and mode bits when reset releases.
// - single-chip modes drive no external bus; bus pins stay general I/O.
// - expanded wide uses ports A and B for multiplexed 16-bit data.
// - expanded narrow uses A and B for address, A alone for data.
// - narrow word transfers run upper byte then lower byte at incremented address.
// - peripheral mode holds the processor; only reset enters or leaves it.
// - mode register is unmapped while in peripheral mode.
// - special bit readable outside peripheral mode; writable in special modes except first write.
// - mode pair: once in normal, all but first in special, never peripheral.
// - stretch off: e clock free runs; on: high external, low hidden internal.
// - stretch forced on when expanded; else once normal, anytime special.
// - visibility shows internal cycles externally, wide in special narrow, never single-chip.
// - visibility bit: once in normal, all but first in special.
// - wait stop shuts external bus after a delay; writable only normal.
// - port k emulation drops its registers when expanded or peripheral.
// - port k emulation bit: once in normal, all but first in special.
// - register, ram and eeprom base fields write once in normal modes; eeprom enable bit anytime.
// - mapping writes take effect by the second cycle after the write.
// - decode order: debug rom, registers, ram, eeprom, flash, external.
// - special single-chip starts debug enabled and active; else enable first.
// - enabled debug is entered by serial command or enter-debug instruction.
// - active debug maps rom at ff20-ffff, registers ff00-ff06, hides user.
// - fixed flash at 4000-7fff and c000-ffff; paged window at 8000-bfff.
`timescale 1ns/100ps
module mcd_mode_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic debug_pin,
  input wire logic mode_select_hi_pin,
  input wire logic mode_select_lo_pin,
  input wire logic [9:0] reg_offset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_access,
  input wire logic cpu_word,
  input wire logic [2:0] page_index,
  input wire logic cpu_wait,
  input wire logic debug_enable_cmd,
  input wire logic debug_serial_enter,
  input wire logic enter_debug_instruction,
  input wire logic debug_exit,
  output mcd_pkg::mcd_region_t map_region,
  output logic [1:0] flash_array,
  output logic map_valid,
  output logic [15:0] ext_addr,
  output logic ext_strobe,
  output logic ext_lane_hi,
  output logic ext_done,
  output logic ext_busy,
  output logic e_clock,
  output logic ext_bus_enable,
  output logic port_b_data,
  output logic visible_cycle,
  output logic port_k_mapped,
  output logic port_e_mapped,
  output logic processor_hold,
  output logic debug_enabled,
  output logic debug_active
);
  logic mode_latched;
  logic special_select_low;
  logic [1:0] mode_select;
  logic e_clock_stretch_enable_store;
  logic internal_bus_visibility;
  logic ext_bus_wait_stop;
  logic port_k_emulate;
  logic port_e_emulate;
  logic mode_written;
  logic [4:0] register_base_map;
  logic [2:0] ram_base_map;
  logic [3:0] eeprom_base_map;
  logic eeprom_on;
  logic reg_map_written;
  logic ram_map_written;
  logic ee_map_written;
  logic [3:0] wait_count;
  logic ext_bus_off;
  logic is_special;
  logic is_periph;
  logic single_chip;
  logic narrow;
  logic expanded;
  logic e_clock_stretch_enable;
  logic vis_on;
  logic mode_wr;
  logic special_later;
  logic normal_once;
  logic seq_start;
  logic [15:0] dec_addr;
  logic dec_word;
  logic [1:0] pin_msel;
  logic [1:0] wr_msel;

  // decoded mode
  assign is_special = !special_select_low;
  assign is_periph = mode_select == mcd_pkg::MSEL_PERIPH;
  assign single_chip = mode_select == mcd_pkg::MSEL_SINGLE;
  assign narrow = mode_select == mcd_pkg::MSEL_NARROW;
  assign expanded = narrow || mode_select == mcd_pkg::MSEL_WIDE;
  assign e_clock_stretch_enable = expanded || e_clock_stretch_enable_store;
  assign vis_on = internal_bus_visibility && !single_chip;
  assign pin_msel = {mode_select_hi_pin, mode_select_lo_pin};
  assign wr_msel = reg_wdata[mcd_pkg::MSEL_HI_BIT:mcd_pkg::MSEL_LO_BIT];

  // write permission classes for the mode register
  assign mode_wr = reg_wr && reg_offset == mcd_pkg::MODE_OFFSET && !is_periph && mode_latched;
  assign special_later = is_special && mode_written;
  assign normal_once = !is_special && !mode_written;

  // mode capture at reset release and guarded software writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_latched <= 1'b0;
      special_select_low <= 1'b1;
      mode_select <= mcd_pkg::MSEL_SINGLE;
      {e_clock_stretch_enable_store, internal_bus_visibility, ext_bus_wait_stop, port_k_emulate, port_e_emulate} <=
        mcd_pkg::NORMAL_OPTS_RESET;
      mode_written <= 1'b0;
    end else if (!mode_latched) begin
      mode_latched <= 1'b1;
      if (debug_pin && pin_msel == mcd_pkg::MSEL_PERIPH) begin
        special_select_low <= 1'b0;
        mode_select <= mcd_pkg::MSEL_PERIPH;
      end else begin
        special_select_low <= debug_pin;
        mode_select <= pin_msel;
      end
      {e_clock_stretch_enable_store, internal_bus_visibility, ext_bus_wait_stop, port_k_emulate, port_e_emulate} <=
        (debug_pin && pin_msel != mcd_pkg::MSEL_PERIPH) ? mcd_pkg::NORMAL_OPTS_RESET : mcd_pkg::SPECIAL_OPTS_RESET;
    end else if (mode_wr) begin
      mode_written <= 1'b1;
      if (special_later) begin
        special_select_low <= reg_wdata[mcd_pkg::SPECIAL_BIT];
      end
      if ((special_later || normal_once) && wr_msel != mcd_pkg::MSEL_PERIPH) begin
        mode_select <= wr_msel;
      end
      if (is_special || normal_once) begin
        e_clock_stretch_enable_store <= reg_wdata[mcd_pkg::STRETCH_BIT];
      end
      if (special_later || normal_once) begin
        internal_bus_visibility <= reg_wdata[mcd_pkg::VIS_BIT];
        port_k_emulate <= reg_wdata[mcd_pkg::EMU_K_BIT];
        port_e_emulate <= reg_wdata[mcd_pkg::EMU_E_BIT];
      end
      if (!is_special) begin
        ext_bus_wait_stop <= reg_wdata[mcd_pkg::WAIT_STOP_BIT];
      end
    end
  end

  // mapping base fields: write once in normal modes, anytime in special; eeprom enable anytime
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      register_base_map <= mcd_pkg::REG_BASE_RESET;
      ram_base_map <= mcd_pkg::RAM_BASE_RESET;
      eeprom_base_map <= mcd_pkg::EE_BASE_RESET;
      eeprom_on <= mcd_pkg::EE_ON_RESET;
      reg_map_written <= 1'b0;
      ram_map_written <= 1'b0;
      ee_map_written <= 1'b0;
    end else if (reg_wr && mode_latched) begin
      if (reg_offset == mcd_pkg::REG_MAP_OFFSET) begin
        reg_map_written <= 1'b1;
        if (is_special || !reg_map_written) begin
          register_base_map <= reg_wdata[7:3];
        end
      end
      if (reg_offset == mcd_pkg::RAM_MAP_OFFSET) begin
        ram_map_written <= 1'b1;
        if (is_special || !ram_map_written) begin
          ram_base_map <= reg_wdata[7:5];
        end
      end
      if (reg_offset == mcd_pkg::EE_MAP_OFFSET) begin
        ee_map_written <= 1'b1;
        if (is_special || !ee_map_written) begin
          eeprom_base_map <= reg_wdata[7:4];
        end
        eeprom_on <= reg_wdata[0] || single_chip;
      end
    end else if (single_chip) begin
      eeprom_on <= 1'b1;
    end
  end

  // register read port, one cycle latency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_offset)
        mcd_pkg::MODE_OFFSET: reg_rdata <= is_periph ? 8'h00 : {special_select_low, mode_select,
          e_clock_stretch_enable, internal_bus_visibility, ext_bus_wait_stop, port_k_emulate, port_e_emulate};
        mcd_pkg::REG_MAP_OFFSET: reg_rdata <= {register_base_map, 3'h0};
        mcd_pkg::RAM_MAP_OFFSET: reg_rdata <= {ram_base_map, 5'h00};
        mcd_pkg::EE_MAP_OFFSET: reg_rdata <= {eeprom_base_map, 3'h0, eeprom_on};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // debug enable and activation
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      debug_enabled <= 1'b0;
      debug_active <= 1'b0;
    end else if (!mode_latched) begin
      debug_enabled <= !debug_pin && pin_msel == mcd_pkg::MSEL_SINGLE;
      debug_active <= !debug_pin && pin_msel == mcd_pkg::MSEL_SINGLE;
    end else begin
      if (debug_enable_cmd && !is_periph) begin
        debug_enabled <= 1'b1;
      end
      if (debug_exit) begin
        debug_active <= 1'b0;
      end else if (debug_enabled && !is_periph && (debug_serial_enter || enter_debug_instruction)) begin
        debug_active <= 1'b1;
      end
    end
  end

  // wait mode shutdown of the external bus after a settling delay
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_count <= 4'h0;
      ext_bus_off <= 1'b0;
    end else if (ext_bus_wait_stop && cpu_wait && !ext_busy) begin
      if (wait_count == mcd_pkg::WAIT_SHUTDOWN_CYCLES) begin
        ext_bus_off <= 1'b1;
      end else begin
        wait_count <= wait_count + 4'h1;
      end
    end else begin
      wait_count <= 4'h0;
      ext_bus_off <= 1'b0;
    end
  end

  // port roles, mapping of emulated ports and processor hold
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_bus_enable <= 1'b0;
      port_b_data <= 1'b0;
      port_k_mapped <= 1'b1;
      port_e_mapped <= 1'b1;
      processor_hold <= 1'b0;
    end else begin
      ext_bus_enable <= (expanded || is_periph) && !ext_bus_off;
      port_b_data <= mode_select == mcd_pkg::MSEL_WIDE || is_periph || (narrow && vis_on && is_special);
      port_k_mapped <= single_chip || !port_k_emulate;
      port_e_mapped <= single_chip || !port_e_emulate;
      processor_hold <= is_periph && mode_latched;
    end
  end

  // e clock and visible internal cycles
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      e_clock <= 1'b0;
      visible_cycle <= 1'b0;
    end else begin
      visible_cycle <= map_valid && vis_on && map_region != mcd_pkg::REGION_EXTERNAL;
      if (!e_clock_stretch_enable) begin
        e_clock <= !e_clock;
      end else begin
        e_clock <= ext_busy || (visible_cycle && !e_clock);
      end
    end
  end

  assign seq_start = map_valid && map_region == mcd_pkg::REGION_EXTERNAL && ext_bus_enable && !ext_busy;

  mcd_map_decode u_decode (
    .clock(clock),
    .rst(rst),
    .addr(cpu_addr),
    .word(cpu_word),
    .access(cpu_access && !processor_hold),
    .debug_active(debug_active),
    .expanded(expanded),
    .reg_base(register_base_map),
    .ram_base(ram_base_map),
    .ee_base(eeprom_base_map),
    .ee_on(eeprom_on),
    .page_index(page_index),
    .region(map_region),
    .flash_array(flash_array),
    .addr_q(dec_addr),
    .word_q(dec_word),
    .valid(map_valid)
  );

  mcd_ext_seq u_seq (
    .clock(clock),
    .rst(rst),
    .start(seq_start),
    .addr(dec_addr),
    .word(dec_word),
    .narrow(narrow),
    .bus_addr(ext_addr),
    .lane_hi(ext_lane_hi),
    .strobe(ext_strobe),
    .done(ext_done),
    .busy(ext_busy)
  );

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  mode_capture_a: assert property ($rose(mode_latched) && !($past(mode_select_hi_pin) && !$past(mode_select_lo_pin))
    |-> special_select_low == $past(debug_pin) && mode_select == $past(pin_msel))
    else $error("mode pins not captured at reset release");
  forced_periph_a: assert property ($rose(mode_latched) && $past(pin_msel) == mcd_pkg::MSEL_PERIPH
    |-> !special_select_low && is_periph)
    else $error("mode 10 not forced to peripheral");
  single_no_bus_a: assert property (single_chip |=> !ext_bus_enable && !port_b_data)
    else $error("external bus enabled in single chip");
  narrow_split_a: assert property (seq_start && narrow && dec_word |=> ext_strobe && ext_lane_hi
    ##1 ext_strobe && !ext_lane_hi && ext_addr == $past(ext_addr) + 16'h0001 ##1 ext_done)
    else $error("narrow word not split into two byte cycles");
  periph_hold_a: assert property (mode_latched && is_periph |=> processor_hold ##1 is_periph)
    else $error("peripheral mode left or processor not held");
  periph_unmapped_a: assert property (reg_rd && reg_offset == mcd_pkg::MODE_OFFSET && is_periph
    |=> reg_rdata == 8'h00)
    else $error("mode register readable in peripheral mode");
  first_write_a: assert property (mode_wr && is_special && !mode_written
    |=> $stable(special_select_low) && $stable(mode_select) && $stable(internal_bus_visibility))
    else $error("first special write to mode register took effect");
  free_eclock_a: assert property (!e_clock_stretch_enable |=> e_clock != $past(e_clock))
    else $error("e clock not free running with stretch off");
  ram_once_a: assert property (reg_wr && reg_offset == mcd_pkg::RAM_MAP_OFFSET && !is_special && ram_map_written
    |=> $stable(ram_base_map))
    else $error("ram map register rewritten in normal mode");
  debug_rom_a: assert property (map_region == mcd_pkg::REGION_DEBUG_ROM
    |-> $past(debug_active) && $past(cpu_addr) >= mcd_pkg::DEBUG_ROM_LO)
    else $error("debug rom selected outside its window");
  fixed_flash_a: assert property (map_region == mcd_pkg::REGION_FLASH && $past(cpu_addr[15:14]) != mcd_pkg::FLASH_PAGE_WIN
    |-> flash_array == mcd_pkg::FIXED_ARRAY)
    else $error("fixed flash window not on fixed array");
  wait_off_a: assert property ($rose(ext_bus_off) |-> $past(ext_bus_wait_stop && cpu_wait))
    else $error("external bus shut without wait stop");

  narrow_word_c: cover property (seq_start && narrow && dec_word ##3 ext_done);
  debug_entry_c: cover property (debug_enabled && !debug_active ##1 debug_active);
  bus_off_c: cover property ($rose(ext_bus_off));
  mode_change_c: cover property (mode_wr && special_later ##1 $changed(mode_select));
endmodule

// ---- hdl/mcd_pkg.sv ----
/*
  constants, encodings and register layout for the mode control and map decode block.
  assumes a 50 MHz bus clock and an 8-bit register port addressed by block offset.
*/
package mcd_pkg;
  // register offsets inside the register block
  localparam logic [9:0] MODE_OFFSET = 10'h00b;
  localparam logic [9:0] RAM_MAP_OFFSET = 10'h010;
  localparam logic [9:0] REG_MAP_OFFSET = 10'h011;
  localparam logic [9:0] EE_MAP_OFFSET = 10'h012;
  // operating mode control bit positions
  localparam int SPECIAL_BIT = 7;
  localparam int MSEL_HI_BIT = 6;
  localparam int MSEL_LO_BIT = 5;
  localparam int STRETCH_BIT = 4;
  localparam int VIS_BIT = 3;
  localparam int WAIT_STOP_BIT = 2;
  localparam int EMU_K_BIT = 1;
  localparam int EMU_E_BIT = 0;
  // option reset values {stretch, visibility, wait stop, emulate k, emulate e}
  localparam logic [4:0] SPECIAL_OPTS_RESET = 5'h1b;
  localparam logic [4:0] NORMAL_OPTS_RESET = 5'h10;
  // mapping register fields and reset values
  localparam logic [4:0] REG_BASE_RESET = 5'h00;
  localparam logic [2:0] RAM_BASE_RESET = 3'h1;
  localparam logic [3:0] EE_BASE_RESET = 4'h0;
  localparam logic EE_ON_RESET = 1'b1;
  // debug window and flash windows
  localparam logic [15:0] DEBUG_ROM_LO = 16'hff20;
  localparam logic [15:0] DEBUG_REG_LO = 16'hff00;
  localparam logic [15:0] DEBUG_REG_HI = 16'hff06;
  localparam logic [1:0] FLASH_LOW_WIN = 2'h1;
  localparam logic [1:0] FLASH_PAGE_WIN = 2'h2;
  localparam logic [1:0] FLASH_HIGH_WIN = 2'h3;
  localparam logic [1:0] FIXED_ARRAY = 2'h3;
  // external bus shutdown delay in wait mode
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int WAIT_SHUTDOWN_NS = 80;
  localparam logic [3:0] WAIT_SHUTDOWN_CYCLES = 4'((WAIT_SHUTDOWN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  // mode select encodings
  typedef enum logic [1:0] {
    MSEL_SINGLE = 2'b00,
    MSEL_NARROW = 2'b01,
    MSEL_PERIPH = 2'b10,
    MSEL_WIDE = 2'b11
  } mcd_msel_t;
  // decoded resource of the current address
  typedef enum logic [2:0] {
    REGION_NONE = 3'b000,
    REGION_DEBUG_ROM = 3'b001,
    REGION_DEBUG_REGS = 3'b010,
    REGION_REGS = 3'b011,
    REGION_RAM = 3'b100,
    REGION_EEPROM = 3'b101,
    REGION_FLASH = 3'b110,
    REGION_EXTERNAL = 3'b111
  } mcd_region_t;
  // external cycle sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FIRST = 2'b01,
    SEQ_LAST = 2'b10
  } mcd_seq_t;
endpackage

// ---- hdl/mcd_map_decode.sv ----
/*
  internal address map decoder with fixed precedence, registered outputs.
  assumes mapping values and debug state come from the mode control block.
*/
`timescale 1ns/100ps
module mcd_map_decode (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic word,
  input wire logic access,
  input wire logic debug_active,
  input wire logic expanded,
  input wire logic [4:0] reg_base,
  input wire logic [2:0] ram_base,
  input wire logic [3:0] ee_base,
  input wire logic ee_on,
  input wire logic [2:0] page_index,
  output mcd_pkg::mcd_region_t region,
  output logic [1:0] flash_array,
  output logic [15:0] addr_q,
  output logic word_q,
  output logic valid
);
  mcd_pkg::mcd_region_t next_region;
  logic [1:0] next_array;

  // precedence chain: debug, registers, ram, eeprom, flash, external
  always_comb begin
    next_array = mcd_pkg::FIXED_ARRAY;
    if (debug_active && addr >= mcd_pkg::DEBUG_ROM_LO) begin
      next_region = mcd_pkg::REGION_DEBUG_ROM;
    end else if (debug_active && addr >= mcd_pkg::DEBUG_REG_LO && addr <= mcd_pkg::DEBUG_REG_HI) begin
      next_region = mcd_pkg::REGION_DEBUG_REGS;
    end else if (debug_active && addr >= mcd_pkg::DEBUG_REG_LO) begin
      next_region = mcd_pkg::REGION_NONE;
    end else if (addr[15:11] == reg_base && !addr[10]) begin
      next_region = mcd_pkg::REGION_REGS;
    end else if (addr[15:13] == ram_base) begin
      next_region = mcd_pkg::REGION_RAM;
    end else if (ee_on && addr[15:12] == ee_base && addr[11]) begin
      next_region = mcd_pkg::REGION_EEPROM;
    end else if (addr[15:14] != 2'h0) begin
      next_region = mcd_pkg::REGION_FLASH;
      if (addr[15:14] == mcd_pkg::FLASH_PAGE_WIN) begin
        next_array = page_index[2:1];
      end
    end else if (expanded) begin
      next_region = mcd_pkg::REGION_EXTERNAL;
    end else begin
      next_region = mcd_pkg::REGION_NONE;
    end
  end

  // one register stage so a mapping write shows in the second cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      region <= mcd_pkg::REGION_NONE;
      flash_array <= 2'h0;
      addr_q <= 16'h0000;
      word_q <= 1'b0;
      valid <= 1'b0;
    end else begin
      region <= next_region;
      flash_array <= next_array;
      addr_q <= addr;
      word_q <= word;
      valid <= access;
    end
  end
endmodule

// ---- hdl/mcd_ext_seq.sv ----
/*
  external bus cycle sequencer: one cycle wide, two byte cycles for narrow words.
  assumes the requester holds off while busy is high.
*/
`timescale 1ns/100ps
module mcd_ext_seq (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] addr,
  input wire logic word,
  input wire logic narrow,
  output logic [15:0] bus_addr,
  output logic lane_hi,
  output logic strobe,
  output logic done,
  output logic busy
);
  mcd_pkg::mcd_seq_t state;

  // narrow words go out upper byte first, then the next address
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= mcd_pkg::SEQ_IDLE;
      bus_addr <= 16'h0000;
      lane_hi <= 1'b0;
      strobe <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
    end else begin
      strobe <= 1'b0;
      done <= 1'b0;
      case (state)
        mcd_pkg::SEQ_IDLE: begin
          if (start) begin
            bus_addr <= addr;
            lane_hi <= !narrow || word || !addr[0];
            strobe <= 1'b1;
            busy <= 1'b1;
            state <= (narrow && word) ? mcd_pkg::SEQ_FIRST : mcd_pkg::SEQ_LAST;
          end
        end
        mcd_pkg::SEQ_FIRST: begin
          bus_addr <= bus_addr + 16'h0001;
          lane_hi <= 1'b0;
          strobe <= 1'b1;
          state <= mcd_pkg::SEQ_LAST;
        end
        mcd_pkg::SEQ_LAST: begin
          done <= 1'b1;
          busy <= 1'b0;
          state <= mcd_pkg::SEQ_IDLE;
        end
        default: begin
          state <= mcd_pkg::SEQ_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ---- verification/mcd_ext_mem_model.sv ----
/*
  far-side memory model of the multiplexed external bus: logs each byte cycle.
  assumes one strobe pulse per external byte or word cycle, bus clock rising edge.
*/
`timescale 1ns/100ps
module mcd_ext_mem_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic ext_strobe,
  input wire logic ext_lane_hi,
  input wire logic [15:0] ext_addr,
  output logic [15:0] first_addr,
  output logic [15:0] second_addr,
  output logic [3:0] cycles
);
  // latch the address of upper and lower lane cycles, count them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cycles <= 4'h0;
      first_addr <= 16'h0000;
      second_addr <= 16'h0000;
    end else if (ext_strobe) begin
      cycles <= cycles + 4'h1;
      if (ext_lane_hi) first_addr <= ext_addr;
      else second_addr <= ext_addr;
    end
  end
endmodule

// ---- verification/mcd_mode_ctrl_tb.sv ----
/*
  self-checking testbench for the mode control and map decode block.
  assumes registered outputs one cycle after their inputs, 50 MHz bus clock.
*/
`timescale 1ns/100ps
module mcd_mode_ctrl_tb;
  logic clock, rst, debug_pin, mode_select_hi_pin, mode_select_lo_pin, reg_wr, reg_rd, cpu_access, cpu_word;
  logic cpu_wait, debug_enable_cmd, debug_serial_enter, enter_debug_instruction, debug_exit;
  logic processor_hold, debug_active, ext_strobe, ext_lane_hi;
  logic ext_bus_enable, port_b_data, port_k_mapped;
  logic [9:0] reg_offset;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] cpu_addr, ext_addr, first_addr, second_addr;
  logic [2:0] page_index;
  logic [1:0] flash_array;
  logic [3:0] cycles;
  mcd_pkg::mcd_region_t map_region;
  int miscompares = 0;
  int comparisons = 0;
  mcd_mode_ctrl u_mcd_mode_ctrl (.clock(clock), .rst(rst), .debug_pin(debug_pin),
    .mode_select_hi_pin(mode_select_hi_pin), .mode_select_lo_pin(mode_select_lo_pin), .reg_offset(reg_offset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr),
    .cpu_access(cpu_access), .cpu_word(cpu_word), .page_index(page_index), .cpu_wait(cpu_wait),
    .debug_enable_cmd(debug_enable_cmd), .debug_serial_enter(debug_serial_enter),
    .enter_debug_instruction(enter_debug_instruction), .debug_exit(debug_exit), .map_region(map_region),
    .flash_array(flash_array), .map_valid(), .ext_addr(ext_addr), .ext_strobe(ext_strobe),
    .ext_lane_hi(ext_lane_hi), .ext_done(), .ext_busy(), .e_clock(), .ext_bus_enable(ext_bus_enable),
    .port_b_data(port_b_data), .visible_cycle(), .port_k_mapped(port_k_mapped), .port_e_mapped(),
    .processor_hold(processor_hold),
    .debug_enabled(), .debug_active(debug_active));
  mcd_ext_mem_model u_mcd_ext_mem_model (.clock(clock), .rst(rst), .ext_strobe(ext_strobe),
    .ext_lane_hi(ext_lane_hi), .ext_addr(ext_addr), .first_addr(first_addr), .second_addr(second_addr),
    .cycles(cycles));
  // bus clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // reset with given mode pins, return just after the second edge after release
  task automatic boot(input logic [2:0] pins);
    @(posedge clock);
    rst <= 1'b1;
    {debug_pin, mode_select_hi_pin, mode_select_lo_pin} <= pins;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [9:0] off, input logic [7:0] d);
    @(posedge clock);
    reg_offset <= off;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] off, input logic [7:0] exp);
    @(posedge clock);
    reg_offset <= off;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(exp));
  endtask
  // one decode lookup, flash array checked for flash hits
  task automatic dec(input logic [15:0] a, input mcd_pkg::mcd_region_t r, input logic [1:0] fa);
    @(posedge clock);
    cpu_addr <= a;
    @(posedge clock);
    #1 chk(16'(map_region), 16'(r));
    if (r == mcd_pkg::REGION_FLASH) chk(16'(flash_array), 16'(fa));
  endtask
  task automatic dbg(input logic [1:0] which);
    @(posedge clock);
    {debug_enable_cmd, debug_serial_enter} <= which;
    @(posedge clock);
    {debug_enable_cmd, debug_serial_enter} <= 2'b00;
  endtask
  // narrow word to external space, two byte cycles seen by the model
  task automatic ext_word;
    int n;
    n = 0;
    @(posedge clock);
    cpu_addr <= 16'h1000;
    cpu_word <= 1'b1;
    cpu_access <= 1'b1;
    @(posedge clock);
    cpu_access <= 1'b0;
    while (cycles !== 4'h2 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (cycles !== 4'h2) begin
      miscompares++;
      end_of_test;
    end
    chk(first_addr, 16'h1000);
    chk(second_addr, 16'h1001);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    {rst, debug_pin, mode_select_hi_pin, mode_select_lo_pin} = 4'hf;
    {reg_wr, reg_rd, cpu_access, cpu_word, cpu_wait} = 5'h00;
    {debug_enable_cmd, debug_serial_enter, enter_debug_instruction, debug_exit} = 4'h0;
    {reg_offset, reg_wdata, cpu_addr, page_index} = '0;
    boot(3'b000);
    rd(10'h00b, 8'h1b);
    chk(16'(debug_active), 16'h0001);
    chk(16'(ext_bus_enable), 16'h0000);
    chk(16'(port_k_mapped), 16'h0001);
    dec(16'hff30, mcd_pkg::REGION_DEBUG_ROM, 2'h0);
    wr(10'h00b, 8'h13);
    rd(10'h00b, 8'h1b);
    wr(10'h00b, 8'h17);
    rd(10'h00b, 8'h13);
    boot(3'b111);
    rd(10'h00b, 8'hf0);
    chk(16'(port_b_data), 16'h0001);
    chk(16'(ext_bus_enable), 16'h0001);
    wr(10'h00b, 8'he4);
    rd(10'h00b, 8'hf4);
    @(posedge clock);
    cpu_wait <= 1'b1;
    repeat (8) @(posedge clock);
    #1 chk(16'(ext_bus_enable), 16'h0000);
    cpu_wait <= 1'b0;
    boot(3'b010);
    chk(16'(processor_hold), 16'h0001);
    chk(16'(port_k_mapped), 16'h0000);
    rd(10'h00b, 8'h00);
    boot(3'b110);
    chk(16'(processor_hold), 16'h0001);
    boot(3'b101);
    rd(10'h00b, 8'hb0);
    chk(16'(port_b_data), 16'h0000);
    ext_word;
    dec(16'h0800, mcd_pkg::REGION_EEPROM, 2'h0);
    dec(16'h4000, mcd_pkg::REGION_FLASH, 2'h3);
    @(posedge clock);
    page_index <= 3'h4;
    dec(16'h8000, mcd_pkg::REGION_FLASH, 2'h2);
    dbg(2'b01);
    dec(16'hff30, mcd_pkg::REGION_FLASH, 2'h3);
    dbg(2'b10);
    dbg(2'b01);
    dec(16'hff30, mcd_pkg::REGION_DEBUG_ROM, 2'h0);
    dec(16'hff03, mcd_pkg::REGION_DEBUG_REGS, 2'h0);
    wr(10'h010, 8'h00);
    dec(16'h0400, mcd_pkg::REGION_RAM, 2'h0);
    dec(16'h0000, mcd_pkg::REGION_REGS, 2'h0);
    wr(10'h010, 8'h60);
    dec(16'h0400, mcd_pkg::REGION_RAM, 2'h0);
    end_of_test;
  end
endmodule
